// ---- alias_match.sv ----
/*
  alias_match: priority decoder of the alias table.
  assumes the alias fields and the incoming address are stable in the
  same cycle; purely combinational.
*/
`timescale 1ns/100ps
module alias_match
  import alias_remap_pkg::*;
(
  // alias table
  input wire logic [NUM_ALIASES*I2C_ADDR_W-1:0] alias_fields,
  // address under test
  input wire logic [I2C_ADDR_W-1:0] target_addr,
  // result
  output logic hit,
  output logic [IDX_W-1:0] hit_index
);

  logic [NUM_ALIASES-1:0] match_vec;

  // --------------------------------------------------------------
  // per-entry compare
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_ALIASES; g++) begin : g_cmp
      // zero alias never matches
      assign match_vec[g] = (alias_fields[g*I2C_ADDR_W +: I2C_ADDR_W] != ALIAS_DISABLED) &&
                            (alias_fields[g*I2C_ADDR_W +: I2C_ADDR_W] == target_addr); // see R4 see R3
    end
  endgenerate

  // lowest index wins
  always_comb begin
    hit = 1'b0;
    hit_index = '0;
    for (int i = NUM_ALIASES - 1; i >= 0; i--) begin
      if (match_vec[i]) begin
        hit = 1'b1; // see R10
        hit_index = IDX_W'(i);
      end
    end
  end

endmodule

// ---- alias_remap.sv ----
/*
  alias_remap: remote target alias translation table and register bank.
  holds eight physical-address entries and six alias entries, and on a
  lookup request swaps a local alias for the configured remote address.
  assumes a plain register port (one-cycle strobes, read data the cycle
  after) and an i2c engine that presents one 7-bit address per request.
  a lookup in the same cycle as a table write sees the old entry, so
  software should reprogram an alias only while its target is idle.
  physical entries six and seven have no alias partner and are never
  used by a lookup; they are plain storage for software.
*/
// Our own choice: strobed register access.
// Overview of operation
// R1: physical entries hold 7-bit remote address, read/write
// R2: matched alias replaced by its physical address
// R3: alias bits 7:1 configure forwarding decoder
// R4: zero alias disables that entry
// R5: alias 0 at 0x10, resets zero
// R6: physical 4..7 at 0x0C..0x0F, bit0 reserved
// R7: alias N pairs with physical entry N
// R8: physical 0..3 at 0x08..0x0B, same layout
// R9: alias 1..5 from 0x11, same behaviour
// R10: lowest matching alias wins, else no forward
`timescale 1ns/100ps
module alias_remap
  import alias_remap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // lookup request from local i2c engine
  input wire logic lookup_valid,
  input wire logic [I2C_ADDR_W-1:0] lookup_addr,
  // lookup answer toward control channel
  output logic fwd_valid,
  output logic fwd_hit,
  output logic [I2C_ADDR_W-1:0] fwd_addr,
  output logic [IDX_W-1:0] fwd_index
);

  // --------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------
  logic [I2C_ADDR_W-1:0] phys_field [NUM_ENTRIES];
  logic [I2C_ADDR_W-1:0] next_phys_field [NUM_ENTRIES];
  logic [I2C_ADDR_W-1:0] alias_field [NUM_ALIASES];
  logic [I2C_ADDR_W-1:0] next_alias_field [NUM_ALIASES];
  logic [NUM_ALIASES*I2C_ADDR_W-1:0] alias_flat;

  logic [DATA_W-1:0] next_reg_rdata;
  logic next_fwd_valid;
  logic next_fwd_hit;
  logic [I2C_ADDR_W-1:0] next_fwd_addr;
  logic [IDX_W-1:0] next_fwd_index;

  logic match_hit;
  logic [IDX_W-1:0] match_index;

  // --------------------------------------------------------------
  // address decode helpers
  // --------------------------------------------------------------
  logic in_phys;
  logic in_alias;
  logic [IDX_W-1:0] phys_sel;
  logic [IDX_W-1:0] alias_sel;
  logic [ADDR_W-1:0] phys_off;
  logic [ADDR_W-1:0] alias_off;

  // entry index from offset within each range
  assign phys_off = reg_addr - PHYS_BASE;
  assign alias_off = reg_addr - ALIAS_BASE;
  assign in_phys = (reg_addr >= PHYS_BASE) && (reg_addr <= PHYS_LAST); // see R6 see R8
  assign in_alias = (reg_addr >= ALIAS_BASE) && (reg_addr <= ALIAS_LAST); // see R5 see R9
  assign phys_sel = phys_off[IDX_W-1:0];
  assign alias_sel = alias_off[IDX_W-1:0];

  // --------------------------------------------------------------
  // register write next state
  // --------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      next_phys_field[i] = phys_field[i];
    end
    for (int j = 0; j < NUM_ALIASES; j++) begin
      next_alias_field[j] = alias_field[j];
    end
    if (reg_wr && in_phys) begin
      next_phys_field[phys_sel] = reg_wdata[FIELD_HI:FIELD_LO]; // see R1
    end
    if (reg_wr && in_alias) begin
      next_alias_field[alias_sel] = reg_wdata[FIELD_HI:FIELD_LO]; // see R3
    end
  end

  // register storage flops, all entries reset to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        phys_field[i] <= FIELD_RESET; // see R6 see R8
      end
      for (int j = 0; j < NUM_ALIASES; j++) begin
        alias_field[j] <= FIELD_RESET; // see R5
      end
    end else begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        phys_field[i] <= next_phys_field[i];
      end
      for (int j = 0; j < NUM_ALIASES; j++) begin
        alias_field[j] <= next_alias_field[j];
      end
    end
  end

  // --------------------------------------------------------------
  // register read path
  // --------------------------------------------------------------
  always_comb begin
    next_reg_rdata = UNMAPPED_READ;
    if (reg_rd && in_phys) begin
      next_reg_rdata = {phys_field[phys_sel], RESERVED_READ}; // see R6
    end else if (reg_rd && in_alias) begin
      next_reg_rdata = {alias_field[alias_sel], RESERVED_READ};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= UNMAPPED_READ;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // --------------------------------------------------------------
  // alias lookup
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_ALIASES; g++) begin : g_flat
      assign alias_flat[g*I2C_ADDR_W +: I2C_ADDR_W] = alias_field[g];
    end
  endgenerate

  alias_match u_match (
    .alias_fields(alias_flat),
    .target_addr(lookup_addr),
    .hit(match_hit),
    .hit_index(match_index)
  );

  // answer one cycle after request; miss forwards nothing
  always_comb begin
    next_fwd_valid = lookup_valid;
    next_fwd_hit = lookup_valid && match_hit; // see R10 see R4
    next_fwd_index = (lookup_valid && match_hit) ? match_index : '0; // index only shown on a hit
    next_fwd_addr = (lookup_valid && match_hit) ? phys_field[match_index] : FIELD_RESET; // see R2 see R7
  end

  // lookup answer flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_hit <= 1'b0;
      fwd_addr <= FIELD_RESET;
      fwd_index <= '0;
    end else begin
      fwd_valid <= next_fwd_valid;
      fwd_hit <= next_fwd_hit;
      fwd_addr <= next_fwd_addr;
      fwd_index <= next_fwd_index;
    end
  end

endmodule

// ---- alias_remap_assertions.sv ----
/* port checker of the alias remap table.
   assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/100ps
module alias_remap_assertions
  import alias_remap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // lookup port
  input wire logic lookup_valid,
  input wire logic [I2C_ADDR_W-1:0] lookup_addr,
  input wire logic fwd_valid,
  input wire logic fwd_hit,
  input wire logic [I2C_ADDR_W-1:0] fwd_addr,
  input wire logic [IDX_W-1:0] fwd_index
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_fwd_answer: assert property (lookup_valid |=> fwd_valid)
    else $error("lookup got no answer");
  a_fwd_unasked: assert property (!lookup_valid |=> !fwd_valid)
    else $error("answer without lookup");
  a_hit_valid: assert property (fwd_hit |-> fwd_valid)
    else $error("hit outside answer");
  a_miss_clean: assert property (fwd_valid && !fwd_hit |-> fwd_addr == 7'h00 && fwd_index == 3'h0)
    else $error("miss carries address");
  a_zero_alias: assert property (lookup_valid && lookup_addr == 7'h00 |=> !fwd_hit)
    else $error("zero alias matched");
  a_index_range: assert property (fwd_hit |-> fwd_index < 3'h6)
    else $error("hit index beyond alias table");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_bit0_low: assert property (reg_rd |=> !reg_rdata[0])
    else $error("reserved bit reads high");
  a_unmapped_rd: assert property (reg_rd && (reg_addr < 8'h08 || reg_addr > 8'h15) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind alias_remap alias_remap_assertions chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr),
  .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_addr(fwd_addr), .fwd_index(fwd_index));

// ---- alias_remap_pkg.sv ----
/*
  package for the remote target alias remap block: register offsets,
  field layout, reset values and table sizes.
  assumes a byte-wide register port with 8-bit addresses.
*/
package alias_remap_pkg;

  // ----------------------------------------------------------------
  // table geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_ENTRIES = 8;
  localparam int unsigned NUM_ALIASES = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned I2C_ADDR_W = 7;
  localparam int unsigned IDX_W = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PHYS_BASE = 8'h08;
  localparam logic [7:0] REMOTE_TARGET_PHYS_ADDR_4 = 8'h0C;
  localparam logic [7:0] REMOTE_TARGET_PHYS_ADDR_5 = 8'h0D;
  localparam logic [7:0] REMOTE_TARGET_PHYS_ADDR_6 = 8'h0E;
  localparam logic [7:0] REMOTE_TARGET_PHYS_ADDR_7 = 8'h0F;
  localparam logic [7:0] PHYS_LAST = 8'h0F;
  localparam logic [7:0] REMOTE_TARGET_ALIAS_0 = 8'h10;
  localparam logic [7:0] ALIAS_BASE = 8'h10;
  localparam logic [7:0] ALIAS_LAST = 8'h15;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FIELD_HI = 7;
  localparam int unsigned FIELD_LO = 1;
  localparam logic [6:0] FIELD_RESET = 7'h00;
  localparam logic [6:0] ALIAS_DISABLED = 7'h00;
  localparam logic RESERVED_READ = 1'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ---- alias_remap_test.sv ----
/* self-checking bench of the alias remap table.
   assumes the lookup_source model and the bound checker. */
`timescale 1ns/100ps
module alias_remap_test;
  import alias_remap_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic lookup_valid, fwd_valid, fwd_hit;
  logic [6:0] lookup_addr, fwd_addr;
  logic [2:0] fwd_index;
  int err_count = 0, samples_checked = 0, cycles = 0;
  // ------------------------------------------------------------
  // clock, device and partner
  // ------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;
  alias_remap uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_valid(lookup_valid),
    .lookup_addr(lookup_addr), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_addr(fwd_addr),
    .fwd_index(fwd_index));
  lookup_source src (.core_clk(core_clk), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr));
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_fwd(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t answer %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic look(input logic [6:0] a, input logic h, input logic [6:0] pa, input logic [2:0] ix);
    src.send(a);
    #1 chk_fwd({fwd_valid, fwd_hit, fwd_addr, fwd_index}, {1'b1, h, pa, ix});
    @(posedge core_clk);
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 8; i < 22; i++) rd(8'(i), 8'h00);
    look(7'h00, 1'b0, 7'h00, 3'h0);
    for (int i = 0; i < 8; i++) wr(8'(8 + i), {7'(7'h30 + i), 1'b1});
    for (int i = 0; i < 8; i++) rd(8'(8 + i), {7'(7'h30 + i), 1'b0});
    for (int i = 0; i < 6; i++) wr(8'(16 + i), {7'(7'h40 + i), 1'b1});
    for (int i = 0; i < 6; i++) rd(8'(16 + i), {7'(7'h40 + i), 1'b0});
    for (int i = 0; i < 6; i++) look(7'(7'h40 + i), 1'b1, 7'(7'h30 + i), 3'(i));
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h00);
    rd(8'h07, 8'h00);
    look(7'h7F, 1'b0, 7'h00, 3'h0);
    wr(8'h13, 8'h83);
    look(7'h41, 1'b1, 7'h31, 3'h1);
    wr(8'h11, 8'h00);
    look(7'h41, 1'b1, 7'h33, 3'h3);
    wr(8'h10, 8'h01);
    look(7'h40, 1'b0, 7'h00, 3'h0);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(8'h0C, 8'h00);
    rd(8'h12, 8'h00);
    look(7'h42, 1'b0, 7'h00, 3'h0);
    give_verdict();
  end
endmodule

// ---- lookup_source.sv ----
/* local i2c engine model: presents one alias per request.
   assumes the caller enters send just after a rising edge. */
`timescale 1ns/100ps
module lookup_source (
  // clock
  input wire logic core_clk,
  // lookup request
  output logic lookup_valid,
  output logic [6:0] lookup_addr
);
  initial begin
    lookup_valid = 1'b0;
    lookup_addr = 7'h55;
  end
  // one-cycle request; released address shows its inverse
  task automatic send(input logic [6:0] a);
    lookup_valid <= 1'b1;
    lookup_addr <= a;
    @(posedge core_clk);
    lookup_valid <= 1'b0;
    lookup_addr <= ~a;
  endtask
endmodule
